//--- rtl/fcs_defs.svh
// Register map, field positions and reset values of the chirp sweep engine
`ifndef FCS_DEFS_SVH
`define FCS_DEFS_SVH

// Byte addresses, first address of a word holds its most significant byte
`define FCS_START_LO   6'h04
`define FCS_START_N    6
`define FCS_STEP_LO    6'h10
`define FCS_STEP_N     6
`define FCS_TIMER_LO   6'h16
`define FCS_TIMER_N    4
`define FCS_DWELL_LO   6'h1A
`define FCS_DWELL_N    3
// Lowest dwell bit carried by the top dwell byte
`define FCS_DWELL_HI_LSB 16
`define FCS_CTRL       6'h1F
`define FCS_FACC_LO    6'h28
`define FCS_FACC_N     6

// Control register fields
`define FCS_CLR_FREQ   7
`define FCS_CLR_BOTH   6
`define FCS_MODE_HI    3
`define FCS_MODE_LO    1
`define FCS_MODE_CHIRP 3'h3
`define FCS_INT_UPD    0

// Reset values
`define FCS_CTRL_RST   8'h00
`define FCS_TIMER_RST  32'h0000_0040
`define FCS_DWELL_RST  20'h0_0001
`define FCS_WORD_RST   48'h0000_0000_0000

`endif

//--- rtl/fcs_pkg.sv
// Types shared by the chirp sweep engine
package fcs_pkg;
    localparam int FCS_FW = 48;
    localparam int FCS_RW = 20;
    localparam int FCS_TW = 32;

    // Parallel register port, one beat per clock
    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } fcs_bus_s;

    // Sweep programming, held twice: buffer and active copy
    typedef struct packed {
        logic [FCS_FW-1:0] start;
        logic [FCS_FW-1:0] step;
        logic [FCS_TW-1:0] period;
        logic [FCS_RW-1:0] dwell;
        logic [7:0]        ctrl;
    } fcs_cfg_s;
endpackage

//--- rtl/fcs_ramp_counter.sv
// Dwell down-counter that paces frequency steps
`timescale 1ns/1ps
`include "fcs_defs.svh"
module fcs_ramp_counter #(
    parameter int W = 20
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         resetn,
    // Control
    input  wire logic         freeze,
    input  wire logic [W-1:0] reload,
    // Step strobe
    output logic              tick
);
    logic [W-1:0] count_reg;

    // Reload only at zero, so a frozen run finishes its old count
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            count_reg <= `FCS_DWELL_RST;
        end else if (!freeze) begin
            if (count_reg == '0) count_reg <= reload;
            else count_reg <= count_reg - 1'b1;
        end
    end

    // One strobe per N+1 clocks
    always_ff @(posedge core_clk) begin
        if (!resetn) tick <= 1'b0;
        else tick <= !freeze && (count_reg == '0);
    end

    // Frozen count stands still; a running one only steps down until zero
    freeze_count_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        freeze |=> $stable(count_reg))
        else $error("dwell count moved while frozen");

    reload_zero_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (!freeze && count_reg != '0) |=> (count_reg == W'($past(count_reg) - 1'b1)))
        else $error("dwell count reloaded before reaching zero");
endmodule

//--- rtl/fcs_update_timer.sv
// Free-running register-update timer
`timescale 1ns/1ps
`include "fcs_defs.svh"
module fcs_update_timer #(
    parameter int W = 32
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         resetn,
    // Control
    input  wire logic         enable,
    input  wire logic [W-1:0] period,
    // Update strobe
    output logic              fire
);
    logic [W-1:0] count_reg;

    // Parked at the period while disabled, fires every period+1 clocks
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            count_reg <= `FCS_TIMER_RST;
            fire      <= 1'b0;
        end else if (!enable) begin
            count_reg <= period;
            fire      <= 1'b0;
        end else if (count_reg == '0) begin
            count_reg <= period;
            fire      <= 1'b1;
        end else begin
            count_reg <= count_reg - 1'b1;
            fire      <= 1'b0;
        end
    end

    // A zero count while enabled must give a strobe next clock
    fire_zero_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (enable && count_reg == '0) |=> fire)
        else $error("update timer missed its zero count");
endmodule

//--- rtl/fcs_sweep_top.sv
// FM chirp frequency-sweep engine with register port and accumulators
//
// Function
// - Start tuning word, 48 bits, at byte addresses 04 to 09.
// - Signed 48-bit step word at byte addresses 10 to 15.
// - 20-bit dwell count at byte addresses 1A to 1C sets step time.
// - Written values act only after a register-update strobe.
// - Step word MSB set sweeps down, clear sweeps up.
// - No end limit; the sweep wraps on forever until stopped.
// - Clear-frequency bit zeroes the frequency accumulator for one clock.
// - That clear leaves the stored step word untouched.
// - Bit left high clears again on every update strobe.
// - Clear-both bit holds frequency and phase accumulators at zero.
// - Registers stay writable while clear-both is high.
// - Hold input freezes the dwell counter, in chirp mode only.
// - After hold, old count finishes before a new dwell loads.
// - Internal 32-bit timer may issue update strobes.
// - A zero step word holds the present frequency.
// - Dwell counter strobes once per N+1 clocks.
// - In chirp mode, each strobe adds the step word into the frequency accumulator.
`timescale 1ns/1ps
`include "fcs_defs.svh"
module fcs_sweep_top #(
    parameter int FW = 48,
    parameter int RW = 20,
    parameter int TW = 32
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             resetn,
    // Parallel register port
    input  wire fcs_pkg::fcs_bus_s reg_bus,
    output logic [7:0]            rd_data,
    // Pins from the host
    input  wire logic             io_update,
    input  wire logic             sweep_hold,
    // Synthesis datapath
    output logic [FW-1:0]         freq_accumulator,
    output logic [FW-1:0]         tuning_word,
    output logic [FW-1:0]         phase_accumulator
);
    import fcs_pkg::*;

    ////////////////////////////////////////////////////////////////
    // Declarations

    fcs_cfg_s      buf_reg;
    fcs_cfg_s      act_reg;
    logic          upd_pin_prev_reg;
    logic          upd_pin_edge;
    logic          timer_fire;
    logic          upd_fire;
    logic          upd_late_reg;
    logic          clr_pulse;
    logic          clr_both;
    logic          chirp_mode;
    logic          freeze;
    logic          ramp_tick;
    logic [7:0]    rd_data_next;

    ////////////////////////////////////////////////////////////////
    // Register port, writes land in the buffer copy

    // Big-endian bytes; any write is taken, clear-both or not
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            buf_reg.start  <= `FCS_WORD_RST;
            buf_reg.step   <= `FCS_WORD_RST;
            buf_reg.period <= `FCS_TIMER_RST;
            buf_reg.dwell  <= `FCS_DWELL_RST;
            buf_reg.ctrl   <= `FCS_CTRL_RST;
        end else if (reg_bus.wr) begin
            for (int k = 0; k < `FCS_START_N; k++) begin
                if (reg_bus.addr == 6'(`FCS_START_LO + k)) begin
                    buf_reg.start[(`FCS_START_N-1-k)*8 +: 8] <= reg_bus.wdata;
                end
            end
            for (int k = 0; k < `FCS_STEP_N; k++) begin
                if (reg_bus.addr == 6'(`FCS_STEP_LO + k)) begin
                    buf_reg.step[(`FCS_STEP_N-1-k)*8 +: 8] <= reg_bus.wdata;
                end
            end
            for (int k = 0; k < `FCS_TIMER_N; k++) begin
                if (reg_bus.addr == 6'(`FCS_TIMER_LO + k)) begin
                    buf_reg.period[(`FCS_TIMER_N-1-k)*8 +: 8] <= reg_bus.wdata;
                end
            end
            // Top byte of the dwell count carries only four bits
            for (int k = 1; k < `FCS_DWELL_N; k++) begin
                if (reg_bus.addr == 6'(`FCS_DWELL_LO + k)) begin
                    buf_reg.dwell[(`FCS_DWELL_N-1-k)*8 +: 8] <= reg_bus.wdata;
                end
            end
            if (reg_bus.addr == `FCS_DWELL_LO) begin
                buf_reg.dwell[RW-1:`FCS_DWELL_HI_LSB] <= reg_bus.wdata[RW-1-`FCS_DWELL_HI_LSB:0];
            end
            if (reg_bus.addr == `FCS_CTRL) begin
                buf_reg.ctrl <= reg_bus.wdata;
            end
        end
    end

    // Read mux: buffer bytes, plus a live view of the accumulator
    always_comb begin
        rd_data_next = 8'h00;
        for (int k = 0; k < `FCS_START_N; k++) begin
            if (reg_bus.addr == 6'(`FCS_START_LO + k)) begin
                rd_data_next = buf_reg.start[(`FCS_START_N-1-k)*8 +: 8];
            end
        end
        for (int k = 0; k < `FCS_STEP_N; k++) begin
            if (reg_bus.addr == 6'(`FCS_STEP_LO + k)) begin
                rd_data_next = buf_reg.step[(`FCS_STEP_N-1-k)*8 +: 8];
            end
        end
        for (int k = 0; k < `FCS_TIMER_N; k++) begin
            if (reg_bus.addr == 6'(`FCS_TIMER_LO + k)) begin
                rd_data_next = buf_reg.period[(`FCS_TIMER_N-1-k)*8 +: 8];
            end
        end
        for (int k = 1; k < `FCS_DWELL_N; k++) begin
            if (reg_bus.addr == 6'(`FCS_DWELL_LO + k)) begin
                rd_data_next = buf_reg.dwell[(`FCS_DWELL_N-1-k)*8 +: 8];
            end
        end
        if (reg_bus.addr == `FCS_DWELL_LO) begin
            rd_data_next = 8'(buf_reg.dwell[RW-1:`FCS_DWELL_HI_LSB]);
        end
        if (reg_bus.addr == `FCS_CTRL) begin
            rd_data_next = buf_reg.ctrl;
        end
        for (int k = 0; k < `FCS_FACC_N; k++) begin
            if (reg_bus.addr == 6'(`FCS_FACC_LO + k)) begin
                rd_data_next = freq_accumulator[(`FCS_FACC_N-1-k)*8 +: 8];
            end
        end
    end

    // Read data is registered; unmapped bytes answer zero
    always_ff @(posedge core_clk) begin
        if (!resetn) rd_data <= 8'h00;
        else if (reg_bus.rd) rd_data <= rd_data_next;
    end

    ////////////////////////////////////////////////////////////////
    // Update strobes: pin edge or internal timer

    // Pin is synchronous, so a plain edge detect is enough
    always_ff @(posedge core_clk) begin
        if (!resetn) upd_pin_prev_reg <= 1'b0;
        else upd_pin_prev_reg <= io_update;
    end

    assign upd_pin_edge = io_update && !upd_pin_prev_reg;

    fcs_update_timer #(
        .W      (TW)
    ) u_timer (
        .core_clk (core_clk),
        .resetn   (resetn),
        .enable   (act_reg.ctrl[`FCS_INT_UPD]),
        .period   (act_reg.period),
        .fire     (timer_fire)
    );

    assign upd_fire = upd_pin_edge || timer_fire;

    // Buffer moves to the active copy only on an update
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            act_reg.start  <= `FCS_WORD_RST;
            act_reg.step   <= `FCS_WORD_RST;
            act_reg.period <= `FCS_TIMER_RST;
            act_reg.dwell  <= `FCS_DWELL_RST;
            act_reg.ctrl   <= `FCS_CTRL_RST;
        end else if (upd_fire) begin
            act_reg <= buf_reg;
        end
    end

    // Delayed strobe, so the one-shot sees the freshly loaded bit
    always_ff @(posedge core_clk) begin
        if (!resetn) upd_late_reg <= 1'b0;
        else upd_late_reg <= upd_fire;
    end

    ////////////////////////////////////////////////////////////////
    // Control decode

    // One clock per update while the bit is active
    assign clr_pulse  = upd_late_reg && act_reg.ctrl[`FCS_CLR_FREQ];
    assign clr_both   = act_reg.ctrl[`FCS_CLR_BOTH];
    assign chirp_mode = act_reg.ctrl[`FCS_MODE_HI:`FCS_MODE_LO] == `FCS_MODE_CHIRP;
    // Hold pin has no effect outside chirp mode
    assign freeze     = sweep_hold && chirp_mode;

    ////////////////////////////////////////////////////////////////
    // Dwell counter

    fcs_ramp_counter #(
        .W      (RW)
    ) u_ramp (
        .core_clk (core_clk),
        .resetn   (resetn),
        .freeze   (freeze),
        .reload   (act_reg.dwell),
        .tick     (ramp_tick)
    );

    ////////////////////////////////////////////////////////////////
    // Frequency accumulator

    // Signed step added as plain modulo sum, so MSB sets direction
    // and nothing stops the sweep at an edge
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            freq_accumulator <= `FCS_WORD_RST;
        end else if (clr_both) begin
            freq_accumulator <= `FCS_WORD_RST;
        end else if (clr_pulse) begin
            freq_accumulator <= `FCS_WORD_RST;
        end else if (ramp_tick && chirp_mode) begin
            // Zero step leaves the frequency where it is
            freq_accumulator <= freq_accumulator + act_reg.step;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Tuning word and phase accumulator

    // Wraps at 2^48 by width; one clock of latency
    always_ff @(posedge core_clk) begin
        if (!resetn) tuning_word <= `FCS_WORD_RST;
        else tuning_word <= act_reg.start + freq_accumulator;
    end

    // Held at zero gives a 0 Hz output
    always_ff @(posedge core_clk) begin
        if (!resetn) phase_accumulator <= `FCS_WORD_RST;
        else if (clr_both) phase_accumulator <= `FCS_WORD_RST;
        else phase_accumulator <= phase_accumulator + tuning_word;
    end

    ////////////////////////////////////////////////////////////////
    // Checks

    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_frozen;
        freeze ##1 (freeze && !clr_both && !clr_pulse);
    endsequence

    sequence s_update_clear;
        upd_fire ##1 act_reg.ctrl[`FCS_CLR_FREQ];
    endsequence

    clear_both_a: assert property (
        clr_both |=> (freq_accumulator == '0) && (phase_accumulator == '0))
        else $error("clear-both did not hold accumulators at zero");

    clear_pulse_a: assert property (
        s_update_clear |=> (freq_accumulator == '0))
        else $error("update with clear bit did not zero accumulator");

    step_kept_a: assert property (
        (clr_pulse && !upd_fire) |=> $stable(act_reg.step))
        else $error("step word changed on accumulator clear");

    update_load_a: assert property (
        upd_fire |=> (act_reg == $past(buf_reg)))
        else $error("update did not load the buffer");

    no_update_a: assert property (
        !upd_fire |=> $stable(act_reg))
        else $error("active settings changed without update");

    accum_step_a: assert property (
        (ramp_tick && chirp_mode && !clr_both && !clr_pulse)
        |=> (freq_accumulator
             == FW'($past(freq_accumulator) + $past(act_reg.step))))
        else $error("accumulator did not add the step word");

    hold_freeze_a: assert property (
        s_frozen |=> $stable(freq_accumulator))
        else $error("accumulator moved during hold");

    zero_step_a: assert property (
        (act_reg.step == '0 && !clr_both && !clr_pulse)
        |=> $stable(freq_accumulator))
        else $error("zero step moved the frequency");

    tuning_sum_a: assert property (
        ##1 (tuning_word
             == FW'($past(act_reg.start) + $past(freq_accumulator))))
        else $error("tuning word is not start plus accumulator");

    write_in_clear_a: assert property (
        (clr_both && reg_bus.wr && reg_bus.addr == `FCS_START_LO)
        |=> (buf_reg.start[FW-1:FW-8] == $past(reg_bus.wdata)))
        else $error("start word write lost while cleared");

    dwell_tick_a: assert property (
        (ramp_tick && !freeze && $past(act_reg.dwell) != '0) |=> !ramp_tick)
        else $error("dwell strobes closer than N+1 clocks");

    // Byte lanes land in the buffer where the map puts them
    start_write_a: assert property (
        (reg_bus.wr && reg_bus.addr == 6'(`FCS_START_LO + `FCS_START_N - 1))
        |=> (8'(buf_reg.start) == $past(reg_bus.wdata)))
        else $error("last start byte write lost");

    step_write_a: assert property (
        (reg_bus.wr && reg_bus.addr == `FCS_STEP_LO)
        |=> (buf_reg.step[FW-1:FW-8] == $past(reg_bus.wdata)))
        else $error("step sign byte write lost");

    dwell_write_a: assert property (
        (reg_bus.wr && reg_bus.addr == `FCS_DWELL_LO)
        |=> (buf_reg.dwell[RW-1:`FCS_DWELL_HI_LSB]
             == $past(reg_bus.wdata[RW-1-`FCS_DWELL_HI_LSB:0])))
        else $error("dwell top nibble write lost");

    acc_view_a: assert property (
        (reg_bus.rd && reg_bus.addr == `FCS_FACC_LO)
        |=> (rd_data == $past(freq_accumulator[FW-1:FW-8])))
        else $error("accumulator read-back did not show the top byte");

    // Phase runs on every clock outside clear-both; the frequency clear lasts a single clock
    phase_add_a: assert property (
        !clr_both |=> (phase_accumulator
                       == FW'($past(phase_accumulator) + $past(tuning_word))))
        else $error("phase accumulator did not add the tuning word");

    clear_one_a: assert property (
        (clr_pulse && !upd_fire) |=> !clr_pulse)
        else $error("frequency clear lasted more than one clock");
endmodule

//--- testbench/fcs_host_model.sv
// Host model: programs sweep registers, pulses update, drives hold
`timescale 1ns/1ps
module fcs_host_model
    import fcs_pkg::*;
(
    // Clock
    input  wire logic         core_clk,
    // Register port
    output fcs_pkg::fcs_bus_s reg_bus,
    input  wire logic [7:0]   rd_data,
    // Pins
    output logic              io_update,
    output logic              sweep_hold
);
    // Idle values at time zero
    initial begin
        reg_bus = '{6'h3F, 8'h00, 1'b0, 1'b0};
        io_update = 1'b0;
        sweep_hold = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte write; released lines flip so a stale copy never looks valid
    task automatic put(input logic [5:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_bus = '{a, d, 1'b1, 1'b0};
        @(negedge core_clk);
        reg_bus = '{~a, ~d, 1'b0, 1'b0};
    endtask

    // Byte read; answer lands one edge after the strobe
    task automatic get(input logic [5:0] a, output logic [7:0] d);
        @(negedge core_clk);
        reg_bus = '{a, ~reg_bus.wdata, 1'b0, 1'b1};
        @(negedge core_clk);
        d = rd_data;
        reg_bus = '{~a, ~reg_bus.wdata, 1'b0, 1'b0};
    endtask

    // Update only once all bytes are in
    task automatic pulse();
        @(negedge core_clk);
        io_update = 1'b1;
        @(negedge core_clk);
        io_update = 1'b0;
    endtask

    // Hold pin level
    task automatic hold(input logic v);
        @(negedge core_clk);
        sweep_hold = v;
    endtask
endmodule

//--- testbench/fcs_sweep_top_tb.sv
// Self-checking bench for the chirp sweep engine
`timescale 1ns/1ps
module fcs_sweep_top_tb;
    import fcs_pkg::*;
    localparam logic [47:0] START  = 48'h0100_0000_0000;
    localparam logic [47:0] START2 = 48'h0200_0000_0000;
    localparam logic [47:0] STEP   = 48'h0000_0012_3400;
    logic        core_clk = 1'b0;
    logic        resetn   = 1'b0;
    fcs_bus_s    reg_bus;
    logic [7:0]  rd_data;
    logic        io_update;
    logic        sweep_hold;
    logic [47:0] facc;
    logic [47:0] tw;
    logic [47:0] pacc;
    int          num_errors = 0;
    int          n_compared = 0;

    // 50 MHz clock
    always #10 core_clk = ~core_clk;

    fcs_host_model host (.core_clk(core_clk), .reg_bus(reg_bus), .rd_data(rd_data),
        .io_update(io_update), .sweep_hold(sweep_hold));

    fcs_sweep_top #(.FW(48), .RW(20), .TW(32)) fcs_sweep_top_inst (
        .core_clk(core_clk), .resetn(resetn), .reg_bus(reg_bus), .rd_data(rd_data),
        .io_update(io_update), .sweep_hold(sweep_hold), .freq_accumulator(facc),
        .tuning_word(tw), .phase_accumulator(pacc));

    ////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Verdict and end of run
    task automatic give_verdict();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Multi-byte access, lowest address holds the top byte
    task automatic put_word(input logic [5:0] b, input int n, input logic [47:0] w);
        for (int i = 0; i < n; i++) begin
            host.put(b + 6'(i), w[8*(n-1-i) +: 8]);
        end
    endtask

    task automatic read_word(input logic [5:0] b, input int n, output logic [47:0] w);
        logic [7:0] d;
        w = '0;
        for (int i = 0; i < n; i++) begin
            host.get(b + 6'(i), d);
            w = {w[39:0], d};
        end
    endtask

    // Cycles until the accumulator moves; bounded so a dead sweep shows
    task automatic wait_step(output int n);
        logic [47:0] v;
        v = facc;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (facc === v && n < 64);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Reset values and an unmapped read
    task automatic t_reset();
        logic [47:0] w;
        read_word(6'h1A, 3, w);
        check(w, 48'h1);
        read_word(6'h1F, 1, w);
        check(w, 48'h0);
        read_word(6'h3F, 1, w);
        check(w, 48'h0);
    endtask

    // Program, read back, nothing moves before the update, then paced steps
    task automatic t_program();
        logic [47:0] w;
        int          n;
        put_word(6'h04, 6, START);
        put_word(6'h10, 6, STEP);
        put_word(6'h1A, 3, 48'h2);
        host.put(6'h1F, 8'h06);
        read_word(6'h04, 6, w);
        check(w, START);
        read_word(6'h10, 6, w);
        check(w, STEP);
        check(tw, 48'h0);
        host.pulse();
        wait_step(n);
        check(facc, STEP);
        // Second step may still come from the count loaded before the update
        wait_step(n);
        check(facc, STEP * 48'd2);
        for (int k = 3; k < 6; k++) begin
            wait_step(n);
            check(48'(n), 48'd3);
            check(facc, STEP * 48'(k));
        end
    endtask

    // Hold freezes; a dwell loaded meanwhile waits for the old count
    task automatic t_hold();
        logic [47:0] v;
        logic [47:0] p;
        int          n;
        host.hold(1'b1);
        repeat (2) @(negedge core_clk);
        v = facc;
        host.put(6'h1C, 8'h05);
        host.pulse();
        repeat (16) @(negedge core_clk);
        check(facc, v);
        check(tw, START + v);
        p = pacc;
        @(negedge core_clk);
        check(pacc, p + tw);
        host.hold(1'b0);
        wait_step(n);
        // Old count of two runs out first, then one clock to the step
        check(48'(n <= 4), 48'h1);
        wait_step(n);
        check(48'(n), 48'd6);
    endtask

    // Clear bit left high clears on every update, step kept
    task automatic t_clear();
        int n;
        host.put(6'h1C, 8'h02);
        host.put(6'h1F, 8'h86);
        for (int k = 0; k < 2; k++) begin
            host.pulse();
            // Cleared one edge after the update edge, before a step can land
            repeat (1) @(negedge core_clk);
            check(facc, 48'h0);
            wait_step(n);
            check(facc, STEP);
        end
    endtask

    // Clear-both holds zero while new start and a down slope are loaded
    task automatic t_both();
        int n;
        host.put(6'h1F, 8'h46);
        host.pulse();
        put_word(6'h04, 6, START2);
        put_word(6'h10, 6, -STEP);
        check(facc, 48'h0);
        check(pacc, 48'h0);
        host.put(6'h1F, 8'h06);
        host.pulse();
        wait_step(n);
        check(facc, -STEP);
        @(negedge core_clk);
        check(tw, START2 - STEP);
    endtask

    // Zero step parks the frequency
    task automatic t_zero();
        logic [47:0] v;
        put_word(6'h10, 6, 48'h0);
        host.pulse();
        repeat (8) @(negedge core_clk);
        v = facc;
        repeat (20) @(negedge core_clk);
        check(facc, v);
    endtask

    // Timer-driven clears give a sawtooth; writes finish before it runs
    task automatic t_timer();
        int          zeros;
        logic [47:0] top;
        put_word(6'h10, 6, STEP);
        put_word(6'h16, 4, 48'h4);
        // Timer parks at the active period, so make the short one active first
        host.pulse();
        host.put(6'h1F, 8'h87);
        host.pulse();
        zeros = 0;
        top = '0;
        repeat (4) @(negedge core_clk);
        repeat (60) begin
            @(negedge core_clk);
            if (facc === 48'h0) zeros++;
            if (facc > top) top = facc;
        end
        check(48'(zeros >= 8), 48'h1);
        check(48'(top <= STEP * 48'd2), 48'h1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (16) @(negedge core_clk);
        resetn = 1'b1;
        t_reset();
        t_program();
        t_hold();
        t_clear();
        t_both();
        t_zero();
        t_timer();
        give_verdict();
    end

    // Watchdog, far beyond the few hundred cycles the run needs
    initial begin
        #200_000;
        num_errors++;
        give_verdict();
    end
endmodule
